// [verif/cmb_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cmb_core_model
    import cmb_pkg::*;
(
    input  wire logic       clock,
    input  wire logic [2:0] txRequest,
    output cmb_rx_head_t    rxHead,
    output cmb_rx_done_t    rxDone,
    output cmb_tx_start_t   txStart,
    output logic            txWon,
    output cmb_tx_done_t    txDone,
    output logic [7:0]      txFaultCount,
    output logic [7:0]      rxFaultCount
);
    initial begin
        rxHead = '0;
        rxDone = '0;
        txStart = '0;
        txWon = 1'b0;
        txDone = '0;
        txFaultCount = 8'h5c;
        rxFaultCount = 8'ha3;
    end

    task automatic rx_head(input logic [10:0] id, input logic rtr, input logic [3:0] dlc);
        @(posedge clock);
        rxHead <= '{1'b1, id, rtr, dlc};
        @(posedge clock);
        // idle header shows garbage, never the last frame
        rxHead <= '{1'b0, ~id, ~rtr, ~dlc};
    endtask

    task automatic rx_done(input logic [63:0] d, input logic ok);
        @(posedge clock);
        rxDone <= '{1'b1, ok, d};
        @(posedge clock);
        rxDone <= '{1'b0, 1'b0, ~d};
    endtask

    task automatic tx_begin(input logic [1:0] b, input logic won);
        int n;
        n = 0;
        while (txRequest[b] !== 1'b1 && n < 8) begin
            @(posedge clock);
            n++;
        end
        if (txRequest[b] === 1'b1) begin
            @(posedge clock);
            txStart <= '{1'b1, b};
            @(posedge clock);
            txStart <= '{1'b0, ~b};
            if (won) begin
                @(posedge clock);
                txWon <= 1'b1;
                @(posedge clock);
                txWon <= 1'b0;
            end
        end
        @(posedge clock);
    endtask

    task automatic tx_end(input logic ok);
        @(posedge clock);
        txDone <= '{1'b1, ok};
        @(posedge clock);
        txDone <= '0;
    endtask
endmodule
`default_nettype wire

// [verif/cmb_msg_buffers_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffers_bench
    import cmb_pkg::*;
();
    logic          clock;
    logic          rst_n;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    cmb_rx_head_t  rxHead;
    cmb_rx_done_t  rxDone;
    cmb_tx_start_t txStart;
    logic          txWon;
    cmb_tx_done_t  txDone;
    logic [7:0]    txFaultCount;
    logic [7:0]    rxFaultCount;
    logic [2:0]    txRequest;
    cmb_tx_frame_t txFrame;
    int            nFail;
    int            checks;
    int            cycles;
    logic [7:0]    rd;
    logic          err;
    logic [63:0]   dat;

    cmb_msg_buffers uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxHead(rxHead), .rxDone(rxDone), .txStart(txStart), .txWon(txWon), .txDone(txDone),
        .txFaultCount(txFaultCount), .rxFaultCount(rxFaultCount), .txRequest(txRequest), .txFrame(txFrame));
    cmb_core_model core (.clock(clock), .txRequest(txRequest), .rxHead(rxHead), .rxDone(rxDone),
        .txStart(txStart), .txWon(txWon), .txDone(txDone), .txFaultCount(txFaultCount),
        .rxFaultCount(rxFaultCount));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // holds the request until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(what, {56'h0, rd}, {56'h0, exp});
    endtask

    task automatic pg(input logic [2:0] p);
        wr(IDX_PAGE, {5'h0, p});
    endtask

    // low nibble written as ones so that read-back shows it is dropped
    task automatic pair(input logic [7:0] b, input logic [11:0] f, input logic [11:0] m);
        wr(b, f[11:4]);
        wr(b + 8'h1, {f[3:0], 4'hf});
        wr(b + 8'h2, m[11:4]);
        wr(b + 8'h3, {m[3:0], 4'hf});
    endtask

    task automatic endTest(input string n);
        $display("test %s done: %0d checks, %0d mismatches", n, checks, nFail);
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            nFail++;
            complete_run();
        end
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        nFail = 0;
        checks = 0;
        dat = 64'h0123456789abcdef;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdc("flags", IDX_FLAGS, 8'h00);
        rdc("enables", IDX_ENABLES, RST_ENABLES);
        rdc("node", IDX_NODE, RST_NODE);
        rdc("presc", IDX_PRESC, RST_PRESC);
        rdc("segs", IDX_SEGS, RST_SEGS);
        wr(IDX_SEGS, 8'hff);
        rdc("segs rw", IDX_SEGS, SEGS_MASK);
        wr(IDX_PAGE, 8'hff);
        rdc("page", IDX_PAGE, 8'h07);
        rdc("reserved", IDX_WIN, 8'h00);
        xfer(1'b0, 8'h50, 8'h00);
        chk("unmapped", err, 1);
        pg(PAGE_DIAG);
        rdc("txfault", IDX_TX_FAULT, 8'h5c);
        rdc("rxfault", IDX_BCTL, 8'ha3);
        endTest("map");
        pg(PAGE_FILT);
        pair(IDX_WIN, {11'h120, 1'b0}, 12'hff0);
        pair(IDX_WIN + 8'h4, {11'h120, 1'b1}, 12'hf01);
        rdc("filt lo", IDX_ID_LOW, 8'h00);
        rdc("mask lo", IDX_FILT_LAST, 8'h10);
        core.rx_head(11'h123, 1'b1, 4'h2);
        pg(PAGE_BUF1);
        rdc("busy rx", IDX_BCTL, 8'h02);
        wr(IDX_BCTL, 8'h01);
        rdc("hold busy", IDX_BCTL, 8'h02);
        core.rx_done(dat, 1'b1);
        rdc("both hit", IDX_BCTL, 8'h04);
        rdc("id hi", IDX_ID_HIGH, 8'h24);
        rdc("id lo", IDX_ID_LOW, 8'h72);
        for (int i = 0; i < 8; i++)
            rdc("data", IDX_DATA0 + 8'(i), dat[63 - 8 * i -: 8]);
        core.rx_head(11'h17d, 1'b1, 4'h0);
        core.rx_done(~dat, 1'b1);
        pg(3'h2);
        rdc("pair1", IDX_BCTL, 8'h0c);
        core.rx_head(11'h17d, 1'b0, 4'h8);
        core.rx_done(dat, 1'b1);
        core.rx_head(11'h121, 1'b0, 4'h1);
        core.rx_done(dat, 1'b0);
        pg(PAGE_BUF3);
        rdc("no hit", IDX_BCTL, 8'h00);
        rdc("pending", IDX_FLAGS, 8'h60);
        endTest("receive");
        pg(3'h2);
        wr(IDX_FLAGS, 8'hbf);
        rdc("acc clr", IDX_BCTL, 8'h04);
        pg(PAGE_BUF1);
        wr(IDX_BCTL, 8'h00);
        rdc("release", IDX_BCTL, 8'h00);
        rdc("flags clr", IDX_FLAGS, 8'h00);
        wr(IDX_BCTL, 8'h01);
        core.rx_head(11'h124, 1'b0, 4'h1);
        core.rx_done(dat, 1'b1);
        rdc("held", IDX_BCTL, 8'h01);
        pg(PAGE_BUF3);
        rdc("skip held", IDX_BCTL, 8'h04);
        endTest("release");
        pg(PAGE_BUF1);
        wr(IDX_ID_HIGH, 8'h54);
        wr(IDX_ID_LOW, 8'ha3);
        for (int i = 0; i < 8; i++)
            wr(IDX_DATA0 + 8'(i), ~dat[63 - 8 * i -: 8]);
        rdc("tx req", IDX_BCTL, 8'h05);
        chk("txRequest", txRequest, 3'b001);
        wr(IDX_FLAGS, 8'h00);
        core.tx_begin(2'd0, 1'b1);
        chk("tx id", txFrame.id, 11'h2a5);
        chk("tx dlc", {txFrame.rtr, txFrame.dlc}, 5'h03);
        chk("tx data", txFrame.data, ~dat);
        rdc("no early", IDX_FLAGS, 8'h00);
        rdc("busy tx", IDX_BCTL, 8'h07);
        core.tx_end(1'b1);
        rdc("served", IDX_BCTL, 8'h01);
        rdc("tx flag", IDX_FLAGS, 8'h10);
        wr(IDX_ENABLES, 8'h01);
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_DATA_LAST, 8'h00);
        core.tx_begin(2'd0, 1'b1);
        rdc("early", IDX_FLAGS, 8'h10);
        core.tx_end(1'b1);
        rdc("early done", IDX_BCTL, 8'h00);
        wr(IDX_BCTL, 8'h01);
        wr(IDX_DATA_LAST, 8'h00);
        rdc("req again", IDX_BCTL, 8'h05);
        wr(IDX_BCTL, 8'h00);
        rdc("cancel", IDX_BCTL, 8'h00);
        chk("cancel req", txRequest, 3'b000);
        endTest("transmit");
        complete_run();
    end
endmodule
`default_nettype wire

// [verilog/cmb_msg_buffers.sv]
// Behaviour
// - identifier low holds id bits 2..0 in bits 7..5; high holds id 10..3.
// - remote bit is one for remote frames, zero for data frames.
// - four-bit length code counts data bytes; only 0 to 8 valid.
// - writing the last data byte of a held buffer raises a transmit request.
// - stored frame gets acceptance bit 0 for pair zero, 1 for pair one only.
// - acceptance bit clears when ready or receive pending flag clears.
// - ready sets on error-free store unheld, or while transmit pending held.
// - software clearing ready of unheld buffer also clears its receive pending flag.
// - held buffer ready cleared by hardware once transmit served or cancelled.
// - busy reads one while core fills or empties the buffer.
// - setting hold stops reception into the buffer, keeps contents.
// - clearing hold returns buffer to receive pool and cancels transmit.
// - successful transmit clears hold only in early-transmit mode.
// - hold writes ignored while buffer is busy.
// - 12-bit filter compared with identifier plus remote bit.
// - mask bit zero is don't-care, one requires equality.
// - filter and mask low registers use bits 7..4; bits 3..0 read zero.
// - paged window layout for buffer and filter pages.
// - three-bit page select picks diagnosis, buffers, filters; 5..7 reserved.
// - transmit flag raised at arbitration won in early mode, else at completion.
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffers
    import cmb_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire cmb_rx_head_t  rxHead,
    input  wire cmb_rx_done_t  rxDone,
    input  wire cmb_tx_start_t txStart,
    input  wire logic          txWon,
    input  wire cmb_tx_done_t  txDone,
    input  wire logic [7:0]    txFaultCount,
    input  wire logic [7:0]    rxFaultCount,
    output logic      [2:0]    txRequest,
    output cmb_tx_frame_t      txFrame
);
    logic [7:0]  idHigh   [NUM_BUFS];
    logic [7:0]  idLow    [NUM_BUFS];
    logic [7:0]  payload  [NUM_BUFS][NUM_BYTES];
    logic [2:0]  lock;
    logic [2:0]  rdy;
    logic [2:0]  acc;
    logic [2:0]  rxPend;
    logic        txFlag;
    logic [11:0] filt     [2];
    logic [11:0] mask     [2];
    logic [7:0]  lastIdHigh;
    logic [7:0]  lastIdLow;
    logic [7:0]  enables;
    logic [7:0]  nodeCtl;
    logic [7:0]  presc;
    logic [7:0]  segs;
    logic [2:0]  page;
    logic        rxActive;
    logic [1:0]  rxBuf;
    logic        rxAccBit;
    logic        txActive;
    logic [1:0]  txBuf;

    function automatic logic filterHit(input logic [11:0] f, input logic [11:0] m, input logic [11:0] key);
        return ((f ^ key) & m) == 12'h000;
    endfunction

    wire [7:0] idx      = paddr[9:2];
    wire       mapped   = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && idx >= IDX_FLAGS && idx <= IDX_BCTL;
    wire       setupPh  = psel & ~penable;
    wire       accessPh = psel & penable;
    wire       wrEn     = accessPh & pwrite & mapped;
    wire [7:0] wOff     = idx - IDX_WIN;
    wire       isBufPg  = page >= PAGE_BUF1 && page <= PAGE_BUF3;
    wire [1:0] pb       = 2'(page - PAGE_BUF1);
    wire       isFiltWin = page == PAGE_FILT && idx >= IDX_WIN && idx <= IDX_FILT_LAST;
    wire       fPair    = wOff[2];
    wire [1:0] fSub     = wOff[1:0];
    wire       early_transmit_irq      = enables[EN_ETX];

    assign pready  = 1'b1;
    assign pslverr = accessPh & ~mapped;

    // busy comes from the core's own transfer state
    wire [2:0] rxBusyVec = rxActive ? 3'(3'b001 << rxBuf) : 3'b000;
    wire [2:0] txBusyVec = txActive ? 3'(3'b001 << txBuf) : 3'b000;
    wire [2:0] busy      = rxBusyVec | txBusyVec;

    // acceptance filtering of the incoming header
    wire [11:0] rxKey  = {rxHead.id, rxHead.rtr};
    wire        hit0   = filterHit(filt[0], mask[0], rxKey);
    wire        hit1   = filterHit(filt[1], mask[1], rxKey);
    wire [2:0]  freeV  = ~lock & ~rdy & ~busy;
    wire        freeAny = |freeV;
    wire [1:0]  freeIdx = freeV[0] ? 2'd0 : (freeV[1] ? 2'd1 : 2'd2);
    wire        rxTake = rxHead.valid & ~rxActive & (hit0 | hit1) & freeAny;
    wire        rxStore = rxDone.valid & rxActive & rxDone.ok;
    wire        txOk    = txDone.valid & txActive & txDone.ok;
    wire        flagsWr = wrEn && idx == IDX_FLAGS;

    assign txRequest = lock & rdy;

    // read path
    logic [7:0] bufRd;
    logic [7:0] rdByte;
    always_comb begin
        bufRd = 8'h00;
        if (idx == IDX_ID_HIGH) begin
            bufRd = idHigh[pb];
        end else if (idx == IDX_ID_LOW) begin
            bufRd = idLow[pb];
        end else if (idx >= IDX_DATA0 && idx <= IDX_DATA_LAST) begin
            bufRd = payload[pb][3'(idx - IDX_DATA0)];
        end else if (idx == IDX_BCTL) begin
            bufRd = {4'h0, acc[pb], rdy[pb], busy[pb], lock[pb]};
        end
    end

    always_comb begin
        rdByte = 8'h00;
        unique case (idx)
            IDX_FLAGS:   rdByte = {rxPend[2], rxPend[1], rxPend[0], txFlag, 4'h0};
            IDX_ENABLES: rdByte = enables;
            IDX_NODE:    rdByte = nodeCtl;
            IDX_PRESC:   rdByte = presc;
            IDX_SEGS:    rdByte = segs;
            IDX_PAGE:    rdByte = {5'h00, page};
            default: begin
                if (isBufPg) begin
                    rdByte = bufRd;
                end else if (isFiltWin) begin
                    unique case (fSub)
                        2'd0: rdByte = filt[fPair][11:4];
                        2'd1: rdByte = {filt[fPair][3:0], 4'h0};
                        2'd2: rdByte = mask[fPair][11:4];
                        2'd3: rdByte = {mask[fPair][3:0], 4'h0};
                    endcase
                end else if (page == PAGE_DIAG) begin
                    if (idx == IDX_ID_HIGH) rdByte = lastIdHigh;
                    if (idx == IDX_ID_LOW) rdByte = lastIdLow;
                    if (idx == IDX_TX_FAULT) rdByte = txFaultCount;
                    if (idx == IDX_BCTL) rdByte = rxFaultCount;
                end
            end
        endcase
    end

    // read data is sampled in the setup phase so pready can stay high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (setupPh) begin
            prdata <= {24'h0, mapped ? rdByte : 8'h00};
        end
    end

    // plain control registers and filters
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enables <= RST_ENABLES;
            nodeCtl <= RST_NODE;
            presc   <= RST_PRESC;
            segs    <= RST_SEGS;
            page    <= RST_PAGE;
            filt    <= '{default: 12'h000};
            mask    <= '{default: 12'h000};
        end else if (wrEn) begin
            if (idx == IDX_ENABLES) enables <= pwdata[7:0];
            if (idx == IDX_NODE) nodeCtl <= pwdata[7:0];
            if (idx == IDX_PRESC) presc <= pwdata[7:0];
            if (idx == IDX_SEGS) segs <= pwdata[7:0] & SEGS_MASK;
            if (idx == IDX_PAGE) page <= pwdata[2:0];
            if (isFiltWin) begin
                unique case (fSub)
                    2'd0: filt[fPair][11:4] <= pwdata[7:0];
                    2'd1: filt[fPair][3:0] <= pwdata[7:4];
                    2'd2: mask[fPair][11:4] <= pwdata[7:0];
                    2'd3: mask[fPair][3:0] <= pwdata[7:4];
                endcase
            end
        end
    end

    // core transfer tracking
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxActive   <= 1'b0;
            rxBuf      <= 2'd0;
            rxAccBit   <= 1'b0;
            txActive   <= 1'b0;
            txBuf      <= 2'd0;
            txFrame    <= '0;
            lastIdHigh <= 8'h00;
            lastIdLow  <= 8'h00;
        end else begin
            if (wrEn && page == PAGE_DIAG && idx == IDX_ID_HIGH) lastIdHigh <= pwdata[7:0];
            if (wrEn && page == PAGE_DIAG && idx == IDX_ID_LOW) lastIdLow <= pwdata[7:0];
            if (rxHead.valid) begin
                lastIdHigh <= rxHead.id[10:3];
                lastIdLow  <= {rxHead.id[2:0], rxHead.rtr, rxHead.dlc};
            end
            if (rxTake) begin
                rxActive <= 1'b1;
                rxBuf    <= freeIdx;
                rxAccBit <= ~hit0;
            end else if (rxDone.valid) begin
                rxActive <= 1'b0;
            end
            if (txStart.valid) begin
                txActive <= 1'b1;
                txBuf    <= txStart.buf_sel;
                txFrame  <= {idHigh[txStart.buf_sel], idLow[txStart.buf_sel][7:4], idLow[txStart.buf_sel][3:0],
                             payload[txStart.buf_sel][0], payload[txStart.buf_sel][1],
                             payload[txStart.buf_sel][2], payload[txStart.buf_sel][3],
                             payload[txStart.buf_sel][4], payload[txStart.buf_sel][5],
                             payload[txStart.buf_sel][6], payload[txStart.buf_sel][7]};
            end else if (txDone.valid) begin
                txActive <= 1'b0;
            end
        end
    end

    // buffer contents; core store overrides a colliding software write
    always_ff @(posedge clock) begin
        for (int b = 0; b < NUM_BUFS; b++) begin
            if (wrEn && isBufPg && pb == 2'(b)) begin
                if (idx == IDX_ID_HIGH) idHigh[b] <= pwdata[7:0];
                if (idx == IDX_ID_LOW) idLow[b] <= pwdata[7:0];
                if (idx >= IDX_DATA0 && idx <= IDX_DATA_LAST) payload[b][3'(idx - IDX_DATA0)] <= pwdata[7:0];
            end
            if (rxTake && freeIdx == 2'(b)) begin
                idHigh[b] <= rxHead.id[10:3];
                idLow[b]  <= {rxHead.id[2:0], rxHead.rtr, rxHead.dlc};
            end
            if (rxStore && rxBuf == 2'(b)) begin
                for (int k = 0; k < NUM_BYTES; k++) begin
                    payload[b][k] <= rxDone.data[8*(7-k) +: 8];
                end
            end
        end
    end

    // buffer status flags; every hardware set is applied after the clears
    logic [2:0] ctlWr;
    logic [2:0] swRdyClr;
    logic [2:0] unlockWr;
    logic [2:0] lastByteWr;
    always_comb begin
        for (int b = 0; b < NUM_BUFS; b++) begin
            ctlWr[b]      = wrEn && isBufPg && pb == 2'(b) && idx == IDX_BCTL;
            swRdyClr[b]   = ctlWr[b] && !lock[b] && !pwdata[BCTL_RDY];
            unlockWr[b]   = ctlWr[b] && !busy[b] && lock[b] && !pwdata[BCTL_LOCK];
            lastByteWr[b] = wrEn && isBufPg && pb == 2'(b) && idx == IDX_DATA_LAST;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock   <= 3'b000;
            rdy    <= 3'b000;
            acc    <= 3'b000;
            rxPend <= 3'b000;
        end else begin
            for (int b = 0; b < NUM_BUFS; b++) begin
                if (ctlWr[b] && !busy[b]) lock[b] <= pwdata[BCTL_LOCK];
                if (txOk && txBuf == 2'(b) && early_transmit_irq) lock[b] <= 1'b0;
                if (swRdyClr[b] || unlockWr[b] || (txOk && txBuf == 2'(b))) begin
                    rdy[b] <= 1'b0;
                    acc[b] <= 1'b0;
                end
                if (swRdyClr[b] || (flagsWr && !pwdata[FLAG_RX0 + b])) begin
                    rxPend[b] <= 1'b0;
                    acc[b]    <= 1'b0;
                end
                if (lastByteWr[b] && lock[b]) rdy[b] <= 1'b1;
                if (rxStore && rxBuf == 2'(b)) begin
                    rdy[b]    <= 1'b1;
                    rxPend[b] <= 1'b1;
                    acc[b]    <= rxAccBit;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txFlag <= 1'b0;
        end else if ((txWon && txActive && early_transmit_irq) || (txOk && !early_transmit_irq)) begin
            txFlag <= 1'b1;
        end else if (flagsWr && !pwdata[FLAG_TX]) begin
            txFlag <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence rxGrab0;
        rxTake && hit0;
    endsequence
    sequence rxFinish;
        rxStore;
    endsequence

    AST_ID_LOW_LAYOUT: assert property (rxTake |=> idLow[rxBuf][7:5] == $past(rxHead.id[2:0]))
        else $error("identifier low bits misplaced");
    AST_RTR_STORED: assert property (rxTake |=> idLow[rxBuf][4] == $past(rxHead.rtr))
        else $error("remote bit not stored");
    AST_LAST_BYTE_REQ: assert property (lastByteWr[pb] && lock[pb] && isBufPg |=> txRequest[$past(pb)])
        else $error("last byte write raised no request");
    AST_ACC_PAIR0: assert property (rxGrab0 ##[1:12] rxFinish |=> acc[$past(rxBuf)] == 1'b0)
        else $error("acceptance bit wrong for pair zero");
    AST_ACC_CLEARED: assert property ((!rdy[0] |-> !acc[0]) and (!rxPend[1] |-> !acc[1]))
        else $error("acceptance bit left set");
    AST_RDY_RXPEND: assert property (swRdyClr[0] && !rxStore |=> !rdy[0] && !rxPend[0])
        else $error("release did not clear pending flag");
    AST_TX_SERVED: assert property (txOk |=> !rdy[$past(txBuf)])
        else $error("ready not cleared after transmit");
    AST_BUSY_TRACK: assert property (txStart.valid |=> busy[$past(txStart.buf_sel)])
        else $error("busy not set while emptying");
    AST_LOCK_BUSY: assert property (busy[2] && !txOk |=> lock[2] == $past(lock[2]))
        else $error("hold changed while busy");
    AST_ETX_KEEP: assert property (txOk && !early_transmit_irq && !ctlWr[txBuf] |=> lock[$past(txBuf)])
        else $error("hold cleared without early mode");
    AST_NO_MATCH: assert property (rxHead.valid && !hit0 && !hit1 |=> !rxActive)
        else $error("unmatched frame taken");
    AST_LOW_ZERO: assert property (setupPh && isFiltWin && fSub[0] |=> prdata[3:0] == 4'h0)
        else $error("filter low bits not zero");

    // transmit side: flag timing and hold release follow the mode bit
    sequence txGrant;
        txWon && txActive && early_transmit_irq;
    endsequence
    sequence txServed;
        txOk && early_transmit_irq;
    endsequence

    AST_ETX_FLAG: assert property (txGrant |=> txFlag)
        else $error("no transmit flag at arbitration");
    AST_DONE_FLAG: assert property (txOk && !early_transmit_irq |=> txFlag)
        else $error("no transmit flag at completion");
    AST_ETX_UNLOCK: assert property (txServed |=> !lock[$past(txBuf)])
        else $error("hold kept in early mode");
    AST_UNLOCK_CANCEL: assert property (unlockWr[0] |=> !rdy[0] && !lock[0])
        else $error("request survived hold clear");
    AST_LOCK_SET: assert property (ctlWr[0] && !busy[0] |=> lock[0] == $past(pwdata[BCTL_LOCK]))
        else $error("hold write not applied");

    // receive side
    AST_ID_HIGH_STORE: assert property (rxTake |=> idHigh[rxBuf] == $past(rxHead.id[10:3]))
        else $error("identifier high bits misplaced");
    AST_DLC_STORED: assert property (rxTake |=> idLow[rxBuf][3:0] == $past(rxHead.dlc))
        else $error("length code not stored");
    AST_HELD_NO_RX: assert property (rxTake |-> !lock[freeIdx])
        else $error("frame taken into held buffer");
    AST_BUSY_RX: assert property (rxTake |=> busy[$past(freeIdx)])
        else $error("busy not set while filling");
    AST_ACC_PAIR1: assert property (rxTake && !hit0 |=> rxAccBit)
        else $error("acceptance bit wrong for pair one");
    AST_RDY_ON_STORE: assert property (rxFinish |=> rdy[$past(rxBuf)] && rxPend[$past(rxBuf)])
        else $error("ready or pending not set on store");

    // page select and reserved pages
    AST_PAGE_SEL: assert property (wrEn && idx == IDX_PAGE |=> page == $past(pwdata[2:0]))
        else $error("page select not written");
    AST_RESERVED_PAGE: assert property (setupPh && page > PAGE_FILT && idx >= IDX_WIN |=> prdata == 32'h0)
        else $error("reserved page reads nonzero");
endmodule
`default_nettype wire

// [verilog/cmb_pkg.sv]
package cmb_pkg;
    localparam int NUM_BUFS = 3;
    localparam int NUM_BYTES = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS = 8'h5a;
    localparam logic [7:0] IDX_ENABLES = 8'h5b;
    localparam logic [7:0] IDX_NODE = 8'h5c;
    localparam logic [7:0] IDX_PRESC = 8'h5d;
    localparam logic [7:0] IDX_SEGS = 8'h5e;
    localparam logic [7:0] IDX_PAGE = 8'h5f;
    localparam logic [7:0] IDX_WIN = 8'h60;
    localparam logic [7:0] IDX_ID_HIGH = 8'h60;
    localparam logic [7:0] IDX_ID_LOW = 8'h61;
    localparam logic [7:0] IDX_DATA0 = 8'h62;
    localparam logic [7:0] IDX_DATA_LAST = 8'h69;
    localparam logic [7:0] IDX_FILT_LAST = 8'h67;
    localparam logic [7:0] IDX_TX_FAULT = 8'h6e;
    localparam logic [7:0] IDX_BCTL = 8'h6f;
    localparam logic [2:0] PAGE_DIAG = 3'h0;
    localparam logic [2:0] PAGE_BUF1 = 3'h1;
    localparam logic [2:0] PAGE_BUF3 = 3'h3;
    localparam logic [2:0] PAGE_FILT = 3'h4;
    localparam int BCTL_ACC = 3;
    localparam int BCTL_RDY = 2;
    localparam int BCTL_BUSY = 1;
    localparam int BCTL_LOCK = 0;
    localparam int FLAG_TX = 4;
    localparam int FLAG_RX0 = 5;
    localparam int EN_ETX = 0;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_NODE = 8'h00;
    localparam logic [7:0] RST_PRESC = 8'h00;
    localparam logic [7:0] RST_SEGS = 8'h23;
    localparam logic [7:0] SEGS_MASK = 8'h7f;
    localparam logic [2:0] RST_PAGE = 3'h0;

    typedef struct packed {
        logic        valid;
        logic [10:0] id;
        logic        rtr;
        logic [3:0]  dlc;
    } cmb_rx_head_t;

    typedef struct packed {
        logic        valid;
        logic        ok;
        logic [63:0] data;
    } cmb_rx_done_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] buf_sel;
    } cmb_tx_start_t;

    typedef struct packed {
        logic        valid;
        logic        ok;
    } cmb_tx_done_t;

    typedef struct packed {
        logic [10:0] id;
        logic        rtr;
        logic [3:0]  dlc;
        logic [63:0] data;
    } cmb_tx_frame_t;
endpackage
